/* hw/wdog_pkg.sv */
// Notes on behaviour
// - Count decrements every 16384 oscillator ticks.
// - Low six counter bits give 64 steps.
// - Active and 40h to 3Fh: reset pulse.
// - Counter decrements whether active or not; activation gates reset.
// - Watchdog comes out of reset inactive unless the hardware-watchdog option is set.
// - Activation sticks until system reset.
// - Activate with top bit clear: immediate reset.
// - Halt while active, halt-reset option set, oscillator interrupt off: reset.
// - Halt-reset and hardware-watchdog options exist.
// - Register write never clears the prescaler.
// - Timebase select picks MSB/LSB constant pair.
// - Minimum timeout formula from LSB, MSB, steps.
// - Maximum timeout formula, less-or-equal threshold.
// - Register resets to 7Fh, activation clear.
// - Hardware option: always active, bit ignored.
// - Plain halt: decrement once, then freeze.
package wdog_pkg;

  // ----------------------------------------------------------------
  // Clock and reset pulse timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int RESET_PULSE_US     = 30;
  localparam int RESET_PULSE_CYCLES =
    (RESET_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int PULSE_W            = $clog2(RESET_PULSE_CYCLES + 1);

  // Oscillator ticks per counter step
  localparam int PRESCALE_DEFAULT   = 16384;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam logic [15:0] CTRL_OFFSET   = 16'h002a;
  localparam logic [7:0]  CTRL_RESET    = 8'h7f;
  localparam int          ACT_BIT       = 7;
  localparam int          TOP_BIT       = 6;
  localparam logic [6:0]  COUNT_RESET   = 7'h7f;
  localparam logic [6:0]  COUNT_EXPIRE  = 7'h40;

  // ----------------------------------------------------------------
  // Timeout formula constants, in oscillator periods
  // ----------------------------------------------------------------
  localparam int TMIN0_OFFSET = 128;
  localparam int GROUP_OFFSET = 192;
  localparam int LSB_SCALE    = 64;
  localparam int STEP_PERIODS = 16384;
  localparam int TMAX0        = 16384;
  localparam int TIME_W       = 24;

  // MSB of the timebase pair
  function automatic int tb_msb(input logic [1:0] sel);
    case (sel)
      2'h0:    return 4;
      2'h1:    return 8;
      2'h2:    return 20;
      default: return 49;
    endcase
  endfunction

  // LSB of the timebase pair
  function automatic int tb_lsb(input logic [1:0] sel);
    case (sel)
      2'h0:    return 59;
      2'h1:    return 53;
      2'h2:    return 35;
      default: return 54;
    endcase
  endfunction

endpackage

/* hw/wdog_prescaler.sv */
`timescale 1ns/1ns
module wdog_prescaler
  import wdog_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_DEFAULT
)
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstSyncN,
  // Oscillator tick and halt gating
  input  wire logic oscTick,
  input  wire logic runEn,
  // Step pulse to the counter
  output      logic stepTick
);

  localparam int CW = $clog2(PRESCALE);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] count;   // Oscillator ticks seen
    logic          tick;    // Step pulse
  } pre_state_t;

  pre_state_t cur_reg;      // Registered state
  pre_state_t cur_next;     // Next state

  // Counts only while runEn is high; no clear input exists, so writes cannot disturb it
  always_comb
  begin
    cur_next      = cur_reg;
    cur_next.tick = 1'b0;
    if (oscTick && runEn)
    begin
      if (cur_reg.count == CW'(PRESCALE - 1))
      begin
        cur_next.count = '0;
        cur_next.tick  = 1'b1;
      end
      else
      begin
        cur_next.count = cur_reg.count + CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign stepTick = cur_reg.tick;

endmodule

/* hw/wdog_timeout_calc.sv */
`timescale 1ns/1ns
module wdog_timeout_calc
  import wdog_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstSyncN,
  // Inputs to the formulas
  input  wire logic [1:0]        timebaseSel,
  input  wire logic [5:0]        stepCount,
  // Timeout bounds in oscillator periods
  output      logic [TIME_W-1:0] timeoutMin,
  output      logic [TIME_W-1:0] timeoutMax
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TIME_W-1:0] tMin;   // Minimum timeout
    logic [TIME_W-1:0] tMax;   // Maximum timeout
  } calc_state_t;

  calc_state_t cur_reg;        // Registered bounds
  calc_state_t cur_next;       // Next bounds

  // Divisors are one of four constants, so the divide stays small
  always_comb
  begin
    int msb;
    int lsb;
    int cnt;
    int grp;
    int var_part;
    msb = tb_msb(timebaseSel);
    lsb = tb_lsb(timebaseSel);
    cnt = int'(stepCount);
    grp = (4 * cnt) / msb;
    var_part = STEP_PERIODS * (cnt - grp)
             + (GROUP_OFFSET + lsb) * LSB_SCALE * grp;
    cur_next = cur_reg;
    // Strict threshold for the minimum
    if (cnt < msb / 4)
      cur_next.tMin = TIME_W'((lsb + TMIN0_OFFSET) * LSB_SCALE
                              + STEP_PERIODS * cnt);
    else
      cur_next.tMin = TIME_W'((lsb + TMIN0_OFFSET) * LSB_SCALE
                              + var_part);
    // Inclusive threshold for the maximum
    if (cnt <= msb / 4)
      cur_next.tMax = TIME_W'(TMAX0 + STEP_PERIODS * cnt);
    else
      cur_next.tMax = TIME_W'(TMAX0 + var_part);
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign timeoutMin = cur_reg.tMin;
  assign timeoutMax = cur_reg.tMax;

endmodule

/* hw/wdog_top.sv */
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module wdog_top
  import wdog_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_DEFAULT
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output      logic [7:0]        regRdata,
  // Clock controller side, same clock domain
  input  wire logic              oscTick,
  input  wire logic              oscIrqEnable,
  input  wire logic [1:0]        timebaseSel,
  // Core side, same clock domain
  input  wire logic              haltExec,
  input  wire logic              wakeEvent,
  // Option byte bits, same clock domain
  input  wire logic              hwWatchdogOpt,
  input  wire logic              haltResetOpt,
  // Outputs
  output      logic              wdogResetN,
  output      logic              wdogActive,
  output      logic [TIME_W-1:0] timeoutMin,
  output      logic [TIME_W-1:0] timeoutMax
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rstSync_reg;     // Release pipeline
  logic       rstSyncN;        // Synchronised reset

  // Asserts at once, releases after two edges
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rstSync_reg <= 2'h0;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end

  assign rstSyncN = rstSync_reg[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,                    // Counting normally
    ST_FROZEN,                 // Halted, counter stopped
    ST_RESETTING               // Driving the reset pulse
  } mode_t;

  typedef struct packed {
    mode_t              mode;       // Operating mode
    logic               active;     // Activation bit
    logic [6:0]         counter;    // Seven-bit down-counter
    logic [PULSE_W-1:0] pulseCnt;   // Reset pulse length
    logic               resetLow;   // Reset output is low
    logic [7:0]         rdata;      // Read data
    logic               optHw;      // Hardware watchdog option
    logic               optHalt;    // Halt reset option
    logic               optsCaught; // Options captured
  } wdog_state_t;

  wdog_state_t cur_reg;             // Registered state
  wdog_state_t cur_next;            // Next state

  logic stepTick;                   // One counter step elapsed
  logic ctrlHit;                    // Address decodes to control
  logic effActive;                  // Reset generation allowed
  logic fire;                       // Start a reset pulse

  // ----------------------------------------------------------------
  // Step prescaler
  // ----------------------------------------------------------------
  // The oscillator is off in halt, so the prescaler pauses too
  wdog_prescaler #(
    .PRESCALE (PRESCALE)
  ) u_prescaler (
    .clk_sys  (clk_sys),
    .rstSyncN (rstSyncN),
    .oscTick  (oscTick),
    .runEn    (cur_reg.mode != ST_FROZEN),
    .stepTick (stepTick)
  );

  // ----------------------------------------------------------------
  // Timeout bound calculator
  // ----------------------------------------------------------------
  // Report the bounds for the step count now loaded
  wdog_timeout_calc u_calc (
    .clk_sys     (clk_sys),
    .rstSyncN    (rstSyncN),
    .timebaseSel (timebaseSel),
    .stepCount   (cur_reg.counter[5:0]),
    .timeoutMin  (timeoutMin),
    .timeoutMax  (timeoutMax)
  );

  // ----------------------------------------------------------------
  // Decode and activation
  // ----------------------------------------------------------------
  assign ctrlHit   = (regAddr == CTRL_OFFSET);
  // Hardware option overrides the activation bit
  assign effActive = cur_reg.active | cur_reg.optHw;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // A write outranks halt, and halt outranks a step in the same cycle
  always_comb
  begin
    cur_next       = cur_reg;
    fire           = 1'b0;
    // Read data stand only in the cycle after the strobe
    cur_next.rdata = 8'h00;
    if (regRd && ctrlHit)
      cur_next.rdata = {cur_reg.active, cur_reg.counter};

    // Option bits caught once, first cycle after release
    if (!cur_reg.optsCaught)
    begin
      cur_next.optHw      = hwWatchdogOpt;
      cur_next.optHalt    = haltResetOpt;
      cur_next.optsCaught = 1'b1;
    end

    case (cur_reg.mode)
      ST_RUN:
      begin
        if (regWr && ctrlHit)
        begin
          // Counter loads at once; the prescaler keeps its phase
          cur_next.counter = regWdata[6:0];
          // Only ever set here; cleared by reset alone
          if (regWdata[ACT_BIT])
            cur_next.active = 1'b1;
          // Top bit written clear while active: software reset
          if ((effActive || regWdata[ACT_BIT]) &&
              !regWdata[TOP_BIT])
            fire = 1'b1;
        end
        else if (haltExec)
        begin
          if (effActive && cur_reg.optHalt && !oscIrqEnable)
          begin
            fire = 1'b1;
          end
          else
          begin
            // Plain halt steps once; active-halt does not
            cur_next.mode = ST_FROZEN;
            if (!oscIrqEnable)
              cur_next.counter = cur_reg.counter - 7'h01;
          end
        end
        else if (stepTick)
        begin
          // Keeps counting whether active or not
          cur_next.counter = cur_reg.counter - 7'h01;
          // Only the 40h to 3Fh step clears the top bit
          if (effActive && cur_reg.counter == COUNT_EXPIRE)
            fire = 1'b1;
        end
      end
      ST_FROZEN:
      begin
        // Frozen counter cannot expire; wait for a wake-up
        if (wakeEvent)
          cur_next.mode = ST_RUN;
      end
      ST_RESETTING:
      begin
        // Pulse length fixed; then back to ST_RUN, counter and activation kept
        if (cur_reg.pulseCnt == PULSE_W'(RESET_PULSE_CYCLES - 1))
          cur_next.mode = ST_RUN;
        else
          cur_next.pulseCnt = cur_reg.pulseCnt + PULSE_W'(1);
      end
      default:
      begin
        cur_next.mode = ST_RUN;
      end
    endcase

    if (fire)
    begin
      cur_next.mode     = ST_RESETTING;
      cur_next.pulseCnt = '0;
    end
    cur_next.resetLow = (cur_next.mode == ST_RESETTING);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Inactive with counter at 7Fh after reset
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      cur_reg            <= '0;
      cur_reg.mode       <= ST_RUN;
      cur_reg.active     <= CTRL_RESET[ACT_BIT];
      cur_reg.counter    <= COUNT_RESET;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata   = cur_reg.rdata;
  assign wdogResetN = ~cur_reg.resetLow;
  assign wdogActive = effActive;

endmodule

/* sim/test_watchdog_downcounter_reset.sv */
`timescale 1ns/1ns
module test_watchdog_downcounter_reset
  import wdog_pkg::*;
;
  // ----------
  // Signals
  // ----------
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [7:0]        regWdata = '0;
  logic              regWr = 1'b0, regRd = 1'b0;
  logic [7:0]        regRdata;
  logic              oscTick = 1'b0, oscIrqEnable = 1'b0;
  logic [1:0]        timebaseSel = 2'h0;
  logic              haltExec = 1'b0, wakeEvent = 1'b0;
  logic              hwWatchdogOpt = 1'b0, haltResetOpt = 1'b0;
  logic              wdogResetN, wdogActive;
  logic [23:0]       timeoutMin, timeoutMax;
  // Reference model state
  int cnt, act, ph, frozen, seed = 32'h6e2ee165;
  int mismatches = 0, numChecks = 0, cyc = 0;
  int msbT[4] = '{4, 8, 20, 49};
  int lsbT[4] = '{59, 53, 35, 54};

  // Short prescale keeps the run brief
  wdog_top #(.PRESCALE(4)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .oscTick(oscTick),
    .oscIrqEnable(oscIrqEnable), .timebaseSel(timebaseSel),
    .haltExec(haltExec), .wakeEvent(wakeEvent),
    .hwWatchdogOpt(hwWatchdogOpt), .haltResetOpt(haltResetOpt),
    .wdogResetN(wdogResetN), .wdogActive(wdogActive),
    .timeoutMin(timeoutMin), .timeoutMax(timeoutMax));

  always #5 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  // ----------
  // Tasks
  // ----------
  task automatic conclude();
    if (mismatches == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic note(input bit bad, input string m);
    numChecks++;
    if (bad)
    begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic cmpReg(input logic [7:0] g, input logic [7:0] e);
    note(g !== e, $sformatf("reg %h want %h", g, e));
  endtask

  task automatic cmpTime(input logic [23:0] g, input logic [23:0] e);
    note(g !== e, $sformatf("time %0d want %0d", g, e));
  endtask

  task automatic cmpFlag(input logic g, input logic e);
    note(g !== e, $sformatf("flag %b want %b", g, e));
  endtask

  // Expected register byte
  function automatic logic [7:0] ctl();
    return {act[0], cnt[6:0]};
  endfunction

  // Timeout bound in oscillator periods
  function automatic int tcalc(input int s, input int c, input bit mx);
    int m, l, g, t;
    m = msbT[s];
    l = lsbT[s];
    g = 4 * c / m;
    t = (mx ? c <= m / 4 : c < m / 4) ? 16384 * c
      : 16384 * (c - g) + (192 + l) * 64 * g;
    return (mx ? 16384 : (l + 128) * 64) + t;
  endfunction

  // All bus tasks start and end right after a rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    cnt = d[6:0];
    act = act | d[7];
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 cmpReg(regRdata, e);
    @(posedge clk_sys);
  endtask

  // Oscillator ticks; a frozen counter ignores them
  task automatic ticks(input int n);
    repeat (n)
    begin
      oscTick <= 1'b1;
      @(posedge clk_sys);
      oscTick <= 1'b0;
      @(posedge clk_sys);
      if (!frozen && ++ph % 4 == 0)
        cnt = (cnt + 127) % 128;
    end
  endtask

  // Ends on the edge that takes the halt, so a halt reset is timed in full
  task automatic halt();
    haltExec <= 1'b1;
    @(posedge clk_sys);
    haltExec <= 1'b0;
  endtask

  task automatic wake();
    wakeEvent <= 1'b1;
    @(posedge clk_sys);
    wakeEvent <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Watch for a reset pulse and measure it in whole cycles
  task automatic pulse(input bit want);
    int low, len;
    len = 0;
    #1 low = !wdogResetN;
    for (int i = 0; i < 12 && !low; i++)
    begin
      @(posedge clk_sys);
      #1 low = !wdogResetN;
    end
    cmpFlag(low[0], want);
    while (low && len < 4000)
    begin
      len++;
      @(posedge clk_sys);
      #1 low = !wdogResetN;
    end
    if (want)
      cmpTime(24'(len), 24'(RESET_PULSE_CYCLES));
    @(posedge clk_sys);
  endtask

  task automatic doReset(input logic hwo, input logic hro);
    rstn <= 1'b0;
    hwWatchdogOpt <= hwo;
    haltResetOpt <= hro;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cnt = 127;
    act = 0;
    ph = 0;
    frozen = 0;
  endtask

  // ----------
  // Sequence
  // ----------
  initial
  begin
    int c;
    doReset(1'b0, 1'b0);
    rdChk(CTRL_OFFSET, 8'h7f);
    cmpFlag(wdogActive, 1'b0);
    rdChk(16'h002b, 8'h00);
    wr(CTRL_OFFSET, 8'h3f);
    pulse(1'b0);
    rdChk(CTRL_OFFSET, ctl());
    // Rolls past 40h while inactive
    wr(CTRL_OFFSET, 8'h41);
    ticks(8);
    pulse(1'b0);
    rdChk(CTRL_OFFSET, ctl());
    // Half a prescale period before the write still counts
    ticks(2);
    wr(CTRL_OFFSET, 8'h7f);
    ticks(2);
    rdChk(CTRL_OFFSET, ctl());
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 4; k++)
      begin
        c = k == 0 ? 0 : k == 1 ? 63 : k == 2 ? msbT[s] / 4
          : $random(seed) & 63;
        timebaseSel <= s[1:0];
        wr(CTRL_OFFSET, {2'b01, c[5:0]});
        repeat (3) @(posedge clk_sys);
        cmpTime(timeoutMin, 24'(tcalc(s, c, 0)));
        cmpTime(timeoutMax, 24'(tcalc(s, c, 1)));
      end
    // Plain halt: one decrement, then frozen
    halt();
    cnt = (cnt + 127) % 128;
    frozen = 1;
    ticks(8);
    pulse(1'b0);
    rdChk(CTRL_OFFSET, ctl());
    wake();
    frozen = 0;
    ticks(4);
    rdChk(CTRL_OFFSET, ctl());
    wr(CTRL_OFFSET, 8'hc5);
    @(posedge clk_sys);
    cmpFlag(wdogActive, 1'b1);
    wr(CTRL_OFFSET, 8'h45);
    rdChk(CTRL_OFFSET, ctl());
    pulse(1'b0);
    wr(CTRL_OFFSET, 8'hc1);
    ticks(8 - ph % 4);
    pulse(1'b1);
    rdChk(CTRL_OFFSET, ctl());
    wr(CTRL_OFFSET, 8'h85);
    pulse(1'b1);
    rdChk(CTRL_OFFSET, ctl());
    doReset(1'b1, 1'b1);
    cmpFlag(wdogActive, 1'b1);
    rdChk(CTRL_OFFSET, ctl());
    // Halt with oscillator interrupt enabled: frozen, no decrement
    oscIrqEnable <= 1'b1;
    halt();
    pulse(1'b0);
    rdChk(CTRL_OFFSET, ctl());
    wake();
    oscIrqEnable <= 1'b0;
    halt();
    pulse(1'b1);
    conclude();
  end
endmodule

/* sim/wdog_top_props.sv */
`timescale 1ns/1ns
module wdog_top_props
  import wdog_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_DEFAULT
)
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  // Clock controller, core, options
  input wire logic              oscTick,
  input wire logic              oscIrqEnable,
  input wire logic [1:0]        timebaseSel,
  input wire logic              haltExec,
  input wire logic              wakeEvent,
  input wire logic              hwWatchdogOpt,
  input wire logic              haltResetOpt,
  // Outputs
  input wire logic              wdogResetN,
  input wire logic              wdogActive,
  input wire logic [TIME_W-1:0] timeoutMin,
  input wire logic [TIME_W-1:0] timeoutMax
);
  // ----------
  // Helpers
  // ----------
  logic [15:0] lowLen_reg;  // Cycles the reset request has been low
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Pulse length counter, cleared while the request is high
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      lowLen_reg <= 16'h0000;
    else if (!wdogResetN)
      lowLen_reg <= lowLen_reg + 16'h0001;
    else
      lowLen_reg <= 16'h0000;
  end

  // ----------
  // Properties
  // ----------
  a_rdata_idle: assert property (
    (!$past(regRd) || $past(regAddr) != CTRL_OFFSET) |-> regRdata == 8'h00)
    else $error("read data not idle");
  a_read_back: assert property (
    regWr && regAddr == CTRL_OFFSET && wdogResetN && !oscTick
    ##1 regRd && regAddr == CTRL_OFFSET && !oscTick
    |=> (regRdata & 8'h7f) == ($past(regWdata, 2) & 8'h7f))
    else $error("counter not loaded by write");
  a_act_sticky: assert property (
    wdogActive |=> wdogActive) else $error("activation dropped");
  a_hw_active: assert property (
    $past(rstn, 6) && hwWatchdogOpt |-> wdogActive)
    else $error("hardware option not active");
  a_write_act: assert property (
    regWr && regAddr == CTRL_OFFSET && regWdata[ACT_BIT] && wdogResetN
    |=> wdogActive) else $error("activation write lost");
  a_soft_reset: assert property (
    regWr && regAddr == CTRL_OFFSET && regWdata[7:6] == 2'b10 && wdogResetN
    |-> ##[1:2] !wdogResetN) else $error("no software reset");
  a_halt_reset: assert property (
    haltExec && wdogActive && haltResetOpt && !oscIrqEnable && wdogResetN
    |-> ##[1:2] !wdogResetN) else $error("no halt reset");
  a_halt_quiet: assert property (
    haltExec && !wdogActive && wdogResetN |=> wdogResetN [*8])
    else $error("reset while inactive halt");
  a_pulse_len: assert property (
    $rose(wdogResetN) |-> lowLen_reg == RESET_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_pulse_max: assert property (
    lowLen_reg <= RESET_PULSE_CYCLES) else $error("reset pulse too long");
  a_cause_act: assert property (
    $fell(wdogResetN) |-> $past(wdogActive) ||
      ($past(regWr) && $past(regAddr) == CTRL_OFFSET &&
       $past(regWdata[ACT_BIT])))
    else $error("reset while inactive");
endmodule

bind wdog_top wdog_top_props #(.PRESCALE(PRESCALE)) i_props (.*);
